// *** pkg/tbfc_defs.vh ***
// Constants for the trace buffer flush control register bank.
// Assumes inclusion by the single design file under rtl/.
`ifndef TBFC_DEFS_VH
`define TBFC_DEFS_VH
// Register byte offsets
`define TBFC_OFF_BASE_HIGH    12'h11C
`define TBFC_OFF_RP_ADVANCE   12'h120
`define TBFC_OFF_FLUSH_STATUS 12'h300
`define TBFC_OFF_FLUSH_CTRL   12'h304
`define TBFC_OFF_MODE_CTRL    12'h310
`define TBFC_OFF_RP_LOW       12'h314
`define TBFC_OFF_RP_HIGH      12'h318
// Field positions in the flush control register
`define TBFC_FC_MARKER   15
`define TBFC_FC_HALT_TRG 13
`define TBFC_FC_HALT_FL  12
`define TBFC_FC_TRG_FL   10
`define TBFC_FC_TRG_EVT  9
`define TBFC_FC_TRG_EXT  8
`define TBFC_FC_MANUAL   6
`define TBFC_FC_FL_TRG   5
`define TBFC_FC_FL_EXT   4
`define TBFC_FC_TI_EN    1
`define TBFC_FC_FMT_EN   0
`define TBFC_FC_MASK     32'h0000B773
// Mode control fields (capture enable, mode, fifo link)
`define TBFC_MC_CAPTURE  0
`define TBFC_MC_MODE_LO  1
`define TBFC_MC_LINK     3
`define TBFC_MODE_CIRC   2'h0
`define TBFC_MODE_SWDRAIN 2'h2
// Status field positions
`define TBFC_FS_PENDING  0
`define TBFC_FS_HALTED   1
// Read-pointer advance value ranges
`define TBFC_RPA_MIN     21'h000010
`define TBFC_RPA_MAX     21'h100000
// Inserted packet ids
`define TBFC_ID_FLUSH    7'h7B
`define TBFC_ID_TRIGGER  7'h7D
// Base high field width
`define TBFC_BASE_HI_W   20
// AXI responses
`define TBFC_RESP_OKAY   2'h0
`define TBFC_RESP_SLVERR 2'h2
`endif

// *** rtl/tbfc_top.v ***
// Flush, trigger and stop control registers of a trace memory controller.
// Assumes one clock, an AXI4-Lite master, and logic-level trace side signals.
//
// What this block does
// - High base register sized address width minus 32; reserved below 33 bits.
// - Base high bits [19:0] hold address bit 32 up; rest read zero.
// - Read-pointer advance ignored when disabled or not software-drained fifo mode.
// - Advance zero does nothing; 0x10 to 0x100000 adds to read pointer.
// - Advance field is write-only bits [20:0]; reads always return zero.
// - Status bit 1 shows formatter halted; clears on enable, holds when disabled.
// - Status bit 0 shows flush pending; frozen while disabled.
// - Marker enable inserts flush id 0x7B after flush in normal formatting.
// - Halt-on-trigger-event stops the formatter on a trigger event.
// - Halt-on-flush: request flush, on ready stop, post-amble, write, complete.
// - Fifo link ignores halt and trigger for master-side initiated flushes.
// - Trigger on flush done marks trigger when flush ready arrives.
// - Trigger on trigger event marks trigger on each event.
// - Trigger on external edge marks trigger on rising trigger input.
// - Manual flush bit starts flush, needs capture, self-clears on completion.
// - Flush on trigger event starts flush unless halt on trigger is set.
// - Inserted trigger is zero byte with source id 0x7D.
// - Flush input rising edge starts flush when enabled and not halted.
`timescale 1ns/1ns
`include "tbfc_defs.vh"

module tbfc_top #(
   parameter ADDR_W = 40
) (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        trigger_event,
   input  wire        trigger_in,
   input  wire        flush_in,
   input  wire        master_flush_req,
   output reg         flush_valid,
   input  wire        flush_ready,
   input  wire        formatter_drained,
   input  wire        memory_written,
   output reg         capture_stop,
   output reg         insert_valid,
   output reg  [6:0]  insert_id,
   output reg  [7:0]  insert_data,
   output reg  [31:0] read_pointer_low,
   output reg  [31:0] read_pointer_high
);

   ////////////////////////////////////////////////////////////////////////
   // Flush handshake states
   localparam ST_IDLE  = 2'b00;
   localparam ST_WAIT  = 2'b01;
   localparam ST_DRAIN = 2'b10;

   localparam HI_W = (ADDR_W > 32) ? ((ADDR_W - 32 > `TBFC_BASE_HI_W) ?
                     `TBFC_BASE_HI_W : ADDR_W - 32) : 1;

   reg [HI_W-1:0] base_high;
   reg [31:0]     flush_ctrl;
   reg [3:0]      mode_ctrl;
   reg            halted_flag;
   reg            pending_flag;
   reg [1:0]      fl_state;
   reg            master_origin;
   reg [1:0]      trig_sync;
   reg [1:0]      flin_sync;
   reg            trig_last;
   reg            flin_last;
   reg            aw_held;
   reg            w_held;
   reg [11:0]     aw_addr;
   reg [31:0]     w_data;
   reg [3:0]      w_strb;

   wire capture_on = mode_ctrl[`TBFC_MC_CAPTURE];
   wire [1:0] mode = mode_ctrl[`TBFC_MC_MODE_LO+1:`TBFC_MC_MODE_LO];
   wire fifo_link  = mode_ctrl[`TBFC_MC_LINK];
   // Formatting active when trigger insertion, formatter enable or non-circular
   wire formatting = flush_ctrl[`TBFC_FC_TI_EN] | flush_ctrl[`TBFC_FC_FMT_EN] |
                     (mode != `TBFC_MODE_CIRC);
   wire ti_en = flush_ctrl[`TBFC_FC_TI_EN];

   ////////////////////////////////////////////////////////////////////////
   // AXI write channel capture, either order
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire [11:0] wa = aw_addr;
   wire wr_ctrl = do_write & (wa == `TBFC_OFF_FLUSH_CTRL);
   wire wr_mode = do_write & (wa == `TBFC_OFF_MODE_CTRL);
   wire wr_known = (wa == `TBFC_OFF_BASE_HIGH) | (wa == `TBFC_OFF_RP_ADVANCE) |
                   (wa == `TBFC_OFF_FLUSH_STATUS) | (wa == `TBFC_OFF_FLUSH_CTRL) |
                   (wa == `TBFC_OFF_MODE_CTRL) | (wa == `TBFC_OFF_RP_LOW) |
                   (wa == `TBFC_OFF_RP_HIGH);
   wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
                            {8{w_strb[0]}}};
   wire [31:0] ctrl_merged = (flush_ctrl & ~strb_mask) | (w_data & strb_mask);

   // Ready pulses once per offer; a held word waits for its partner
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TBFC_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `TBFC_RESP_OKAY : `TBFC_RESP_SLVERR;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and edge detect
   // Last-value flops reset low like the idle pins: no edge after reset
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_sync <= 2'b00;
         flin_sync <= 2'b00;
         trig_last <= 1'b0;
         flin_last <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[0], trigger_in};
         flin_sync <= {flin_sync[0], flush_in};
         trig_last <= trig_sync[1];
         flin_last <= flin_sync[1];
      end
   end
   wire trig_rise = trig_sync[1] & ~trig_last;
   wire flin_rise = flin_sync[1] & ~flin_last;

   ////////////////////////////////////////////////////////////////////////
   // Flush request sources
   wire halt_trg = flush_ctrl[`TBFC_FC_HALT_TRG];
   wire man_start = wr_ctrl & capture_on & w_strb[0] & w_data[`TBFC_FC_MANUAL];
   wire evt_start = trigger_event & flush_ctrl[`TBFC_FC_FL_TRG] & ~halt_trg;
   wire ext_start = flin_rise & flush_ctrl[`TBFC_FC_FL_EXT] & ~halted_flag;
   // manual bit left set by a write racing completion relaunches
   wire man_held  = flush_ctrl[`TBFC_FC_MANUAL] & (fl_state == ST_IDLE);
   // later sources fold into the one outstanding flush
   wire any_start = (man_start | man_held | evt_start | ext_start | master_flush_req) &
                    capture_on;
   // Flush completes on ready in bypass, after memory write when formatting
   wire fl_done = (fl_state == ST_WAIT & flush_ready & ~formatting) |
                  (fl_state == ST_DRAIN & memory_written);
   wire got_ready = (fl_state == ST_WAIT) & flush_ready;

   ////////////////////////////////////////////////////////////////////////
   // Flush handshake engine
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fl_state      <= ST_IDLE;
         flush_valid   <= 1'b0;
         master_origin <= 1'b0;
      end else begin
         case (fl_state)
            ST_IDLE: begin
               if (any_start) begin
                  fl_state      <= ST_WAIT;
                  flush_valid   <= 1'b1;
                  master_origin <= master_flush_req & fifo_link &
                                   ~(man_start | man_held | evt_start | ext_start);
               end
            end
            ST_WAIT: begin
               if (flush_ready) begin
                  flush_valid <= 1'b0;
                  fl_state    <= formatting ? ST_DRAIN : ST_IDLE;
               end
            end
            ST_DRAIN: begin
               if (memory_written) begin
                  fl_state <= ST_IDLE;
               end
            end
            default: begin
               fl_state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and mode registers
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flush_ctrl <= 32'h00000000;
         mode_ctrl  <= 4'h0;
      end else begin
         if (wr_mode & w_strb[0]) begin
            mode_ctrl <= w_data[3:0];
         end
         // Manual bit only taken while capture runs; set beats clear
         if (wr_ctrl) begin
            flush_ctrl <= (ctrl_merged & `TBFC_FC_MASK & ~(32'h1 << `TBFC_FC_MANUAL)) |
                          ({31'h0, man_start} << `TBFC_FC_MANUAL);
         end else if (fl_done) begin
            flush_ctrl[`TBFC_FC_MANUAL] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags, halt and packet insertion
   // Master-side flushes in link setup never halt on flush or insert a trigger
   wire allow_stop = ~master_origin;
   // Enabling capture clears status before a new flush reports
   wire go_live    = wr_mode & w_strb[0] & w_data[`TBFC_MC_CAPTURE] & ~capture_on;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         halted_flag  <= 1'b0;
         pending_flag <= 1'b0;
         capture_stop <= 1'b0;
         insert_valid <= 1'b0;
         insert_id    <= 7'h00;
         insert_data  <= 8'h00;
      end else begin
         insert_valid <= 1'b0;
         insert_data  <= 8'h00;
         // Status flags freeze while capture is off
         if (go_live) begin
            halted_flag  <= 1'b0;
            pending_flag <= 1'b0;
            capture_stop <= 1'b0;
         end else if (capture_on) begin
            pending_flag <= (fl_state != ST_IDLE) | any_start;
            halted_flag  <= capture_stop & formatter_drained;
            if (trigger_event & halt_trg) begin
               capture_stop <= 1'b1;
            end
            if (got_ready & flush_ctrl[`TBFC_FC_HALT_FL] & allow_stop) begin
               capture_stop <= 1'b1;
            end
            // Trigger marker wins a tie; that cycle's flush id is lost
            // trigger insertion sources
            if (ti_en & ((got_ready & flush_ctrl[`TBFC_FC_TRG_FL] & allow_stop) |
                (trigger_event & flush_ctrl[`TBFC_FC_TRG_EVT]) |
                (trig_rise & flush_ctrl[`TBFC_FC_TRG_EXT]))) begin
               insert_valid <= 1'b1;
               insert_id    <= `TBFC_ID_TRIGGER;
            end else if (fl_done & formatting & flush_ctrl[`TBFC_FC_MARKER]) begin
               insert_valid <= 1'b1;
               insert_id    <= `TBFC_ID_FLUSH;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Base high and read pointer
   // Advance carries from the low half into the high half
   wire [20:0] adv = w_data[20:0];
   wire adv_ok = (adv >= `TBFC_RPA_MIN) & (adv <= `TBFC_RPA_MAX);
   wire [63:0] rp_sum = {read_pointer_high, read_pointer_low} + {43'h0, adv};
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         base_high         <= {HI_W{1'b0}};
         read_pointer_low  <= 32'h00000000;
         read_pointer_high <= 32'h00000000;
      end else if (do_write) begin
         if (wa == `TBFC_OFF_BASE_HIGH && ADDR_W > 32) begin
            base_high <= w_data[HI_W-1:0];
         end
         // Pointer halves load directly only while capture is off
         if (wa == `TBFC_OFF_RP_LOW && !capture_on) begin
            read_pointer_low <= w_data;
         end
         if (wa == `TBFC_OFF_RP_HIGH && !capture_on) begin
            read_pointer_high <= {12'h000, w_data[19:0]};
         end
         // advance only when live in fifo mode
         if (wa == `TBFC_OFF_RP_ADVANCE && capture_on && mode == `TBFC_MODE_SWDRAIN &&
             adv_ok) begin
            read_pointer_low  <= rp_sum[31:0];
            read_pointer_high <= {12'h000, rp_sum[51:32]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI read channel
   // Unmapped offsets answer SLVERR with zero data
   reg [31:0] rd_val;
   reg        rd_ok;
   always @* begin
      rd_val = 32'h00000000;
      rd_ok  = 1'b1;
      case ({s_axi_araddr[11:2], 2'b00})
         `TBFC_OFF_BASE_HIGH:    rd_val[HI_W-1:0] = (ADDR_W > 32) ? base_high : {HI_W{1'b0}};
         `TBFC_OFF_RP_ADVANCE:   rd_val = 32'h00000000;
         `TBFC_OFF_FLUSH_STATUS: rd_val = {30'h0, halted_flag, pending_flag};
         `TBFC_OFF_FLUSH_CTRL:   rd_val = flush_ctrl;
         `TBFC_OFF_MODE_CTRL:    rd_val = {28'h0, mode_ctrl};
         `TBFC_OFF_RP_LOW:       rd_val = read_pointer_low;
         `TBFC_OFF_RP_HIGH:      rd_val = read_pointer_high;
         default:                rd_ok  = 1'b0;
      endcase
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `TBFC_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `TBFC_RESP_OKAY : `TBFC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// *** verification/tbfc_checker.sv ***
// Concurrent checks on the flush control block's top ports.
// Assumes one clock domain and the async active low reset.
`timescale 1ns/1ns
module tbfc_checker (
   input wire        sys_clk,
   input wire        arst_n,
   input wire        s_axi_awready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        flush_valid,
   input wire        flush_ready,
   input wire        capture_stop,
   input wire        insert_valid,
   input wire [6:0]  insert_id,
   input wire [7:0]  insert_data,
   input wire [31:0] read_pointer_low
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////
   a_fv_hold: assert property (flush_valid && !flush_ready |=> flush_valid)
      else $error("flush request dropped before its response");
   a_fv_drop: assert property (flush_valid && flush_ready |=> !flush_valid)
      else $error("flush request kept after its response");
   a_ins_zero: assert property (insert_valid |-> insert_data == 8'h00)
      else $error("inserted packet payload not zero");
   a_ins_id_ok: assert property (insert_valid |-> insert_id inside {7'h7D, 7'h7B})
      else $error("inserted packet id not a marker id");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready longer than one cycle");
   a_ar_to_r: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_adv_reads_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h120
      |=> s_axi_rdata == 32'h00000000)
      else $error("advance register read not zero");
   a_base_top_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h11C
      |=> s_axi_rdata[31:20] == 12'h000)
      else $error("base high upper bits not zero");
   a_rp_on_write: assert property (!$stable(read_pointer_low) |-> s_axi_bvalid)
      else $error("read pointer moved without a write");
   // Main scenarios
   c_flush: cover property (flush_valid && flush_ready);
   c_fl_id: cover property (insert_valid && insert_id == 7'h7B);
   c_trg_id: cover property (insert_valid && insert_id == 7'h7D);
   c_halt: cover property ($rose(capture_stop));
endmodule
bind tbfc_top tbfc_checker u_chk (.*);

// *** verification/tbfc_partner.sv ***
// Upstream trace source and memory side answering flush requests.
// Assumes the bench sets the response delay in cycles.
`timescale 1ns/1ns
module tbfc_partner (
   input  wire       sys_clk,
   input  wire       arst_n,
   input  wire [7:0] delay,
   input  wire       flush_valid,
   input  wire       capture_stop,
   output logic      flush_ready,
   output logic      memory_written,
   output logic      formatter_drained
);
   logic [7:0] cnt;
   logic [3:0] mw;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 8'h00;
         flush_ready <= 1'b0;
         mw <= 4'h0;
         memory_written <= 1'b0;
         formatter_drained <= 1'b0;
      end else begin
         flush_ready <= flush_valid && !flush_ready && (cnt >= delay);
         if (flush_valid && !flush_ready) begin
            cnt <= (cnt >= delay) ? 8'h00 : cnt + 8'h01;
         end
         mw <= {mw[2:0], flush_valid & flush_ready};
         memory_written <= mw[3];
         formatter_drained <= capture_stop;
      end
   end
endmodule

// *** verification/trace_buffer_flush_control_tb.sv ***
// Self-checking bench for the flush control register bank.
// Assumes the partner model on the flush side and an AXI4-Lite master here.
`timescale 1ns/1ns
module trace_buffer_flush_control_tb;
   logic sys_clk = 0, arst_n = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, read_pointer_low, read_pointer_high;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, trigger_event = 0, trigger_in = 0, flush_in = 0;
   logic master_flush_req = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic flush_valid, flush_ready, formatter_drained, memory_written, capture_stop;
   logic insert_valid, fv_q = 0;
   logic [6:0] insert_id;
   logic [7:0] insert_data, delay = 8'h02;
   logic [31:0] d, v, tbl [6];
   logic [63:0] rp;
   int checked = 0, miscompares = 0, n7d = 0, n7b = 0, nfv = 0, a7, af, i;
   tbfc_top #(.ADDR_W(52)) dut (.*);
   tbfc_partner u_part (.*);
   ////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and insert monitor
   initial forever #50 sys_clk = ~sys_clk;
   initial begin
      #4000000;
      miscompares++;
      report_and_stop;
   end
   always @(posedge sys_clk) begin
      if (insert_valid === 1'b1 && insert_id === 7'h7D) n7d <= n7d + 1;
      if (insert_valid === 1'b1 && insert_id === 7'h7B) n7b <= n7b + 1;
      if (flush_valid === 1'b1 && !fv_q) nfv <= nfv + 1;
      fv_q <= (flush_valid === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      begin
         $display("checked=%0d miscompares=%0d", checked, miscompares);
         if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checked++;
         if (g !== e) begin
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
            miscompares++;
         end
      end
   endtask
   // Write with both channels offered together
   task axi_wr(input [11:0] a, input [31:0] dv, input [1:0] er);
      int n;
      begin
         @(posedge sys_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= dv;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
         n = 0;
         @(posedge sys_clk);
         while (s_axi_bvalid !== 1'b1 && n < 60) begin
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
            n++;
            @(posedge sys_clk);
         end
         chk("bvalid", 1, s_axi_bvalid);
         s_axi_bready <= 0;
         s_axi_awvalid <= 0;
         s_axi_wvalid <= 0;
         chk("bresp", er, s_axi_bresp);
      end
   endtask
   task axi_rd(input [11:0] a, input [1:0] er, output [31:0] dv);
      int n;
      begin
         @(posedge sys_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
         n = 0;
         @(posedge sys_clk);
         while (s_axi_rvalid !== 1'b1 && n < 60) begin
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
            n++;
            @(posedge sys_clk);
         end
         chk("rvalid", 1, s_axi_rvalid);
         s_axi_arvalid <= 0;
         s_axi_rready <= 0;
         dv = s_axi_rdata;
         chk("rresp", er, s_axi_rresp);
      end
   endtask
   task fire(input [3:0] k);
      begin
         trigger_event <= (k == 0);
         trigger_in <= (k == 1);
         flush_in <= (k == 2);
         @(posedge sys_clk);
         trigger_event <= 0;
         repeat (5) @(posedge sys_clk);
         trigger_in <= 0;
         flush_in <= 0;
      end
   endtask
   task poll_man;
      int n;
      begin
         n = 0;
         axi_rd(12'h304, 0, d);
         while (d[6] !== 1'b0 && n < 50) begin
            axi_rd(12'h304, 0, d);
            n++;
         end
      end
   endtask
   function [63:0] adv(input [31:0] x);
      adv = (x >= 32'h10 && x <= 32'h100000) ? {32'h0, x} : 64'h0;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // Fields: control, stimulus, triggers, flushes, halted
      tbl = '{32'h0202_0100, 32'h0102_1100, 32'h0200_0000,
              32'h2020_0001, 32'h0020_0010, 32'h0010_2010};
      void'($urandom(32'h3E9A210C));
      repeat (10) @(posedge sys_clk);
      arst_n <= 1;
      repeat (2) @(posedge sys_clk);
      axi_rd(12'h11C, 0, d); chk("base_rst", 0, d);
      axi_rd(12'h304, 0, d); chk("ctrl_rst", 0, d);
      // Base high set while disabled; only bits [19:0] read back
      for (i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hFFFFFFFF : $urandom;
         axi_wr(12'h11C, v, 0);
         axi_rd(12'h11C, 0, d); chk("base_high", v & 32'h000FFFFF, d);
      end
      axi_wr(12'h304, 32'hFFFFFFFF, 0);
      axi_rd(12'h304, 0, d); chk("ctrl_bits", 32'h0000B733, d);
      axi_wr(12'h200, 32'h1, 2'h2);
      axi_rd(12'h200, 2'h2, d);
      axi_wr(12'h304, 0, 0);
      axi_wr(12'h314, 32'hFFFFFF00, 0);
      rp = 64'hFFFFFF00;
      axi_wr(12'h120, 32'h100, 0);
      axi_wr(12'h310, 1, 0);
      axi_wr(12'h120, 32'h100, 0);
      chk("rp_ignored", rp[31:0], read_pointer_low);
      axi_wr(12'h310, 0, 0);
      axi_wr(12'h310, 5, 0);
      for (i = 0; i < 8; i++) begin
         v = (i == 0) ? 0 : (i == 1) ? 32'h100000 : (i == 2) ? 32'h10
             : (($urandom % 32'h10000) + 1) << 4;
         axi_wr(12'h120, v, 0);
         rp = rp + adv(v);
         chk("rp_low", rp[31:0], read_pointer_low);
         chk("rp_high", rp[63:32], read_pointer_high);
      end
      axi_rd(12'h120, 0, d); chk("adv_read", 0, d);
      for (i = 0; i < 6; i++) begin
         axi_wr(12'h310, 0, 0);
         axi_wr(12'h304, {16'h0, tbl[i][31:16]}, 0);
         axi_wr(12'h310, 1, 0);
         a7 = n7d;
         af = nfv;
         fire(tbl[i][15:12]);
         repeat (40) @(posedge sys_clk);
         chk("trig_ins", tbl[i][11:8], n7d - a7);
         chk("flushes", tbl[i][7:4], nfv - af);
         chk("halted", tbl[i][3:0], capture_stop);
      end
      // Manual flush with marker, merged requests, slow answer
      delay <= 8'd30;
      axi_wr(12'h310, 0, 0);
      axi_wr(12'h304, 32'h8011, 0);
      axi_wr(12'h310, 1, 0);
      af = nfv;
      a7 = n7b;
      axi_wr(12'h304, 32'h8051, 0);
      axi_rd(12'h300, 0, d); chk("pending", 1, d[0]);
      fire(2);
      axi_wr(12'h304, 32'h8051, 0);
      poll_man; chk("manual_clr", 0, d[6]);
      chk("one_flush", 1, nfv - af);
      chk("flush_id", 1, n7b - a7);
      axi_rd(12'h300, 0, d); chk("pend_clr", 0, d[0]);
      // Halt and trigger on flush done
      delay <= $urandom % 8;
      axi_wr(12'h310, 0, 0);
      axi_wr(12'h304, 32'h1403, 0);
      axi_wr(12'h310, 1, 0);
      a7 = n7d;
      axi_wr(12'h304, 32'h1443, 0);
      poll_man;
      chk("trg_on_fl", 1, n7d - a7);
      chk("stop_on_fl", 1, capture_stop);
      axi_rd(12'h300, 0, d); chk("halt_flag", 1, d[1]);
      axi_wr(12'h310, 0, 0);
      axi_rd(12'h300, 0, d); chk("halt_kept", 1, d[1]);
      axi_wr(12'h310, 1, 0);
      axi_rd(12'h300, 0, d); chk("halt_clr", 0, d[1]);
      // Master side flush in link configuration
      axi_wr(12'h310, 0, 0);
      axi_wr(12'h310, 9, 0);
      a7 = n7d;
      master_flush_req <= 1;
      @(posedge sys_clk);
      master_flush_req <= 0;
      repeat (60) @(posedge sys_clk);
      chk("link_stop", 0, capture_stop);
      chk("link_trg", 0, n7d - a7);
      report_and_stop;
   end
endmodule
